// ### dv/pod_control_status_map_bench.sv
// Purpose: self-checking bench of the pod control/status map
// Assumes: read data one cycle after rd_i, writes effective next cycle
// Notes:   mainframe model sits on the cable side
`timescale 1ns/1ps
`default_nettype none
module pod_control_status_map_bench;
  import pod_map_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, external_unit_reset_n_i = 1'b0;
  logic wr_i = 1'b0, rd_i = 1'b0, abort_i = 1'b0, break_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  word_t wdata_i = 16'h0000, target_lines_i = 16'h5a2b, low_drive_i = 16'h1357;
  word_t ctrl_drive_i = 16'h2468, data_drive_i = 16'h9bdf;
  logic [6:0] sync_status_i = 7'h35;
  logic [7:0] mf_send = 8'hab, mf_seen, main_data_i, main_data_o;
  logic mf_stat = 1'b1, mf_supply = 1'b1, mainframe_status_in_i, supply_ok_flag_i;
  logic main_data_oe_o, status_to_mainframe_o, cpu_reset_o;
  logic busy_counter_carry_o, target_on_request_o, run_target_on_o, target_on_o;
  word_t rdata_o, out_port_o, line_enable_o, standby_hi_o;
  logic [3:0] upper_addr_o;
  word_t overlay_o, bkpt_hi_o, bkpt_lo_o;
  logic [7:0] pat [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
  int bad_count = 0, compares = 0;
  wire [3:0] timing = {busy_counter_carry_o, target_on_request_o, run_target_on_o, target_on_o};
  pod_control_status_map i_dut (
    .clk_i, .sys_rst_i, .external_unit_reset_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .main_data_i, .mainframe_status_in_i, .supply_ok_flag_i, .main_data_o, .main_data_oe_o,
    .status_to_mainframe_o, .abort_i, .break_i, .target_lines_i, .low_drive_i, .ctrl_drive_i,
    .data_drive_i, .sync_status_i, .cpu_reset_o, .out_port_o, .line_enable_o, .standby_hi_o,
    .upper_addr_o, .overlay_o, .bkpt_hi_o, .bkpt_lo_o, .busy_counter_carry_o,
    .target_on_request_o, .run_target_on_o, .target_on_o);
  pod_mainframe_model i_mainframe (
    .clk_i(clk_i), .pod_data_i(main_data_o), .pod_oe_i(main_data_oe_o), .data_o(main_data_i),
    .status_o(mainframe_status_in_i), .supply_o(supply_ok_flag_i), .send_i(mf_send),
    .stat_i(mf_stat), .supply_i(mf_supply), .seen_o(mf_seen));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input word_t a, input word_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input word_t a, input word_t exp, input word_t mask);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & mask, exp);
  endtask
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    external_unit_reset_n_i <= 1'b1;
    #1 chk(timing, 4'hf);
    chk(out_port_o, 16'h0000);
    rd(16'hd800, 16'hf9ab, 16'hffff);
    @(posedge clk_i);
    mf_supply <= 1'b0;
    mf_stat <= 1'b0;
    rd(16'hd800, 16'hf0ab, 16'hffff);
    foreach (pat[i]) begin
      wr(16'hc800, {8'h01, pat[i]});
      chk({main_data_oe_o, mf_seen}, {1'b1, pat[i]});
    end
    wr(16'hc800, 16'h0000);
    chk({status_to_mainframe_o, main_data_oe_o}, 2'b00);
    wr(16'hc800, 16'h0800);
    chk({status_to_mainframe_o, main_data_oe_o}, 2'b10);
    wr(16'hc800, 16'h0155);
    wr(16'hd000, 16'h8421);
    wr(16'hd800, 16'h0000);
    chk(line_enable_o, 16'h8421);
    chk({main_data_oe_o, main_data_o}, 9'h155);
    wr(16'hc000, 16'hbeef);
    chk(standby_hi_o, 16'hbeef);
    wr(16'he800, 16'h00a5);
    wr(16'hfb00, 16'hffff);
    wr(16'hfc00, 16'hffff);
    wr(16'hfd00, 16'hffff);
    chk({12'h000, upper_addr_o}, 16'h000a);
    chk(overlay_o, 16'hffe7);
    chk(bkpt_hi_o, 16'h00ff);
    chk(bkpt_lo_o, 16'hfffe);
    rd(16'hf000, 16'h1357, 16'hffff);
    rd(16'he000, 16'h0035, 16'hffff);
    rd(16'hf200, 16'h5a2b, 16'hffef);
    wr(16'h0000, 16'h1234);
    wr(16'h3ffe, 16'hedcb);
    rd(16'h0000, 16'h1234, 16'hffff);
    rd(16'h3ffe, 16'hedcb, 16'hffff);
    rd(16'h8000, 16'h0000, 16'hffff);
    @(posedge clk_i);
    abort_i <= 1'b1;
    break_i <= 1'b1;
    @(posedge clk_i);
    abort_i <= 1'b0;
    break_i <= 1'b0;
    rd(16'hd800, 16'ha000, 16'hf000);
    @(posedge clk_i);
    external_unit_reset_n_i <= 1'b0;
    rd(16'hf200, 16'h0010, 16'h0010);
    chk({main_data_oe_o, mf_seen}, 9'h0aa);
    chk(out_port_o, 16'h0000);
    @(posedge clk_i);
    external_unit_reset_n_i <= 1'b1;
    rd(16'hd800, 16'hf000, 16'hf000);
    rd(16'hf200, 16'h0000, 16'h0010);
    wr(16'hf800, 16'h0000);
    chk(cpu_reset_o, 1'b1);
    repeat (9) @(posedge clk_i);
    #1 chk(cpu_reset_o, 1'b0);
    rd(16'hd800, 16'hd000, 16'hf000);
    wr(16'hf900, 16'h0000);
    rd(16'hd800, 16'hf000, 16'hf000);
    wr(16'hfa00, 16'h0000);
    chk(target_on_request_o, 1'b0);
    repeat (12) @(posedge clk_i);
    #1 chk(timing, 4'hf);
    finish_test;
  end
endmodule // pod_control_status_map_bench
`default_nettype wire

// ### dv/pod_mainframe_model.sv
// Purpose: test mainframe at the far end of the pod cable
// Assumes: bench commands the byte and status lines it sends
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module pod_mainframe_model (
  // clock
  input  wire logic       clk_i,
  // pod side
  input  wire logic [7:0] pod_data_i,
  input  wire logic       pod_oe_i,
  output logic      [7:0] data_o,
  output logic            status_o,
  output logic            supply_o,
  // bench side
  input  wire logic [7:0] send_i,
  input  wire logic       stat_i,
  input  wire logic       supply_i,
  output logic      [7:0] seen_o
);
  logic [7:0] last_r;
  assign data_o = send_i;
  assign status_o = stat_i;
  assign supply_o = supply_i;
  // a floating cable must not read back the old byte by luck
  // clocked capture: byte and enable drop in one step at reset, no race between them
  always_ff @(posedge clk_i) if (pod_oe_i) last_r <= pod_data_i;
  assign seen_o = pod_oe_i ? pod_data_i : ~last_r;
endmodule // pod_mainframe_model
`default_nettype wire

// ### dv/pod_map_properties.sv
// Purpose: port properties of the pod control/status map
// Assumes: bound to the map top, read data one cycle after rd_i
// Notes:   pod reset low blanks the outgoing port
`timescale 1ns/1ps
`default_nettype none
module pod_map_properties (
  // clock and resets
  input wire logic               clk_i,
  input wire logic               sys_rst_i,
  input wire logic               external_unit_reset_n_i,
  // processor bus
  input wire logic        [15:0] addr_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire pod_map_pkg::word_t wdata_i,
  input wire pod_map_pkg::word_t rdata_o,
  // mainframe link and causes
  input wire logic        [7:0]  main_data_i,
  input wire logic               mainframe_status_in_i,
  input wire logic               supply_ok_flag_i,
  input wire logic               abort_i,
  input wire logic               break_i,
  input wire logic        [7:0]  main_data_o,
  input wire logic               main_data_oe_o,
  input wire logic               status_to_mainframe_o,
  // control outputs
  input wire pod_map_pkg::word_t out_port_o,
  input wire logic               cpu_reset_o,
  input wire logic               busy_counter_carry_o,
  input wire logic               target_on_request_o,
  input wire logic               run_target_on_o,
  input wire logic               target_on_o
);
  import pod_map_pkg::*;
  word_t       wdata_r;
  logic [11:0] in_r;
  logic        ext_r;
  wire         ok = external_unit_reset_n_i;
  wire         hit_out = wr_i && addr_i == 16'hc800;
  wire         rd_in = rd_i && addr_i == 16'hd800;
  wire [3:0]   timing = {busy_counter_carry_o, target_on_request_o, run_target_on_o, target_on_o};
  // cause side one cycle behind, to line up with registered answers
  always_ff @(posedge clk_i) begin
    wdata_r <= wdata_i;
    in_r <= {supply_ok_flag_i, 1'b0, abort_i, mainframe_status_in_i, main_data_i};
    ext_r <= external_unit_reset_n_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_out_byte_shown: assert property (
    ok && hit_out |=> main_data_o == wdata_r[7:0] && main_data_oe_o == wdata_r[8])
    else $error("outgoing byte or enable wrong");
  chk_out_byte_held: assert property (
    ok && !hit_out |=> $stable(main_data_o)) else $error("outgoing byte moved");
  chk_status_line: assert property (
    ok && hit_out |=> status_to_mainframe_o == wdata_r[11]) else $error("status line wrong");
  chk_reset_blanks: assert property (
    !ok |=> out_port_o == 16'h0000 && !main_data_oe_o) else $error("port not blanked");
  chk_reset_visible: assert property (
    rd_i && addr_i == 16'hf200 |=> rdata_o[4] == !ext_r) else $error("reset bit wrong");
  chk_incoming_word: assert property (
    rd_in |=> rdata_o[11:0] == in_r) else $error("incoming word wrong");
  chk_flags_idle: assert property (
    !ok ##1 (ok && !abort_i && !break_i && !cpu_reset_o) ##1 rd_in
    |=> rdata_o[14:12] == 3'h7)
    else $error("cause flags not idle");
  chk_timing_idle: assert property (
    !ok ##1 !(wr_i && addr_i == 16'hfa00) |-> timing == 4'hf) else $error("timing not idle");
  chk_self_pulse: assert property (
    ok && wr_i && addr_i == 16'hf800 |=> cpu_reset_o [*8] ##1 !cpu_reset_o)
    else $error("self reset pulse wrong");
  chk_ton_request: assert property (
    ok && wr_i && addr_i == 16'hfa00 |=> !target_on_request_o) else $error("no request");
  cover property (ok && hit_out && wdata_i[8]);
  cover property ($fell(external_unit_reset_n_i));
  cover property (!target_on_o);
endmodule // pod_map_properties
bind pod_control_status_map pod_map_properties i_chk (
  .clk_i, .sys_rst_i, .external_unit_reset_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
  .main_data_i, .mainframe_status_in_i, .supply_ok_flag_i, .abort_i, .break_i, .main_data_o,
  .main_data_oe_o, .status_to_mainframe_o, .out_port_o, .cpu_reset_o, .busy_counter_carry_o,
  .target_on_request_o, .run_target_on_o, .target_on_o);
`default_nettype wire

// ### rtl/pod_control_status_map.sv
// Purpose: control and status register map of the emulator pod
// Assumes: synchronous pod processor bus, one-cycle write strobe, read data next cycle
// Notes:   ram window 0000..3ffe; registers on the upper page
`timescale 1ns/1ps
`default_nettype none
`include "pod_map_consts.svh"

// Notes on behaviour
// - outgoing write with bit 8 set enables data driver; low byte shown
// - outgoing low byte held until next outgoing write or reset
// - incoming port read returns mainframe data in low byte
// - incoming word bit 8 shows mainframe status line
// - incoming word bit 11 shows supply ok, high when normal
// - outgoing bit 11 drives pod status line to mainframe
// - external unit reset shown live as reset status bit 4 while asserted, not latched; reads return zero during sys_rst_i
// - during pod reset the data driver is disabled
// - during pod reset every outgoing port bit forced low
// - after external reset the three cause flags read high
// - after reset all four bus switch timing signals read high
// - processor reset is active high, low in normal operation
// - local ram covers byte addresses 0000 through 3ffe, 8192 words
// - strobe writes cause self reset, monitor clear, target-on request
module pod_control_status_map (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  external_unit_reset_n_i,
  // pod processor bus
  input  wire logic  [15:0] addr_i,
  input  wire logic  wr_i,
  input  wire logic  rd_i,
  input  wire pod_map_pkg::word_t wdata_i,
  output pod_map_pkg::word_t rdata_o,
  // mainframe link
  input  wire logic  [7:0] main_data_i,
  input  wire logic  mainframe_status_in_i,
  input  wire logic  supply_ok_flag_i,
  output logic       [7:0] main_data_o,
  output logic       main_data_oe_o,
  output logic       status_to_mainframe_o,
  // reset cause inputs
  input  wire logic  abort_i,
  input  wire logic  break_i,
  // sampled target lines
  input  wire pod_map_pkg::word_t target_lines_i,
  input  wire pod_map_pkg::word_t low_drive_i,
  input  wire pod_map_pkg::word_t ctrl_drive_i,
  input  wire pod_map_pkg::word_t data_drive_i,
  input  wire logic  [6:0] sync_status_i,
  // control outputs
  output logic       cpu_reset_o,
  output pod_map_pkg::word_t out_port_o,
  output pod_map_pkg::word_t line_enable_o,
  output pod_map_pkg::word_t standby_hi_o,
  output logic       [3:0] upper_addr_o,
  output pod_map_pkg::word_t overlay_o,
  output pod_map_pkg::word_t bkpt_hi_o,
  output pod_map_pkg::word_t bkpt_lo_o,
  output logic       busy_counter_carry_o,
  output logic       target_on_request_o,
  output logic       run_target_on_o,
  output logic       target_on_o
);
  import pod_map_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  pod_ram_if ram ();

  wire  pod_rst      = sys_rst_i | ~external_unit_reset_n_i;
  wire  ram_sel      = addr_i <= `RAM_TOP;
  wire  wr_out       = wr_i & hit(addr_i, `OFS_OUT_PORT);
  wire  wr_self      = wr_i & hit(addr_i, `OFS_SELF_RESET);
  wire  wr_clear     = wr_i & hit(addr_i, `OFS_MON_CLEAR);
  wire  wr_ton       = wr_i & hit(addr_i, `OFS_TON_REQ);
  wire  ton_carry;
  wire  ton_req;
  wire  ton_run;
  wire  ton_on;

  word_t      out_r;
  logic       oe_r;
  logic [2:0] flags_r;
  logic [3:0] self_cnt_r;
  logic       ram_rd_r;
  logic       rd_pend_r;
  word_t      reg_rdata_r;
  word_t      in_word;
  word_t      reg_rdata_nxt;

  // ------------------------------------------------------------
  // ram
  // ------------------------------------------------------------
  assign ram.we    = wr_i & ram_sel;
  assign ram.addr  = addr_i[13:1];
  assign ram.wdata = wdata_i;

  pod_local_ram #(.DEPTH(8192)) u_ram (
    .clk_i (clk_i),
    .ram   (ram.mem)
  );

  pod_target_on u_ton (
    .clk_i     (clk_i),
    .rst_i     (pod_rst),
    .req_i     (wr_ton),
    .carry_o   (ton_carry),
    .request_o (ton_req),
    .run_o     (ton_run),
    .on_o      (ton_on)
  );

  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (pod_rst) begin
      out_r <= `RST_WORD;
      oe_r  <= 1'b0;
    end else if (wr_out) begin
      out_r <= wdata_i;
      oe_r  <= wdata_i[`BIT_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (pod_rst) begin
      line_enable_o <= `RST_WORD;
      standby_hi_o  <= `RST_WORD;
      upper_addr_o  <= 4'h0;
      overlay_o     <= `RST_WORD;
      bkpt_hi_o     <= `RST_WORD;
      bkpt_lo_o     <= `RST_WORD;
    end else if (wr_i) begin
      if (hit(addr_i, `OFS_LINE_ENABLE)) line_enable_o <= wdata_i;
      if (hit(addr_i, `OFS_STANDBY_HI))  standby_hi_o  <= wdata_i;
      if (hit(addr_i, `OFS_UPPER_ADDR))  upper_addr_o  <= wdata_i[7:4];
      if (hit(addr_i, `OFS_OVERLAY))     overlay_o     <= {wdata_i[15:5], 2'h0, wdata_i[2:0]};
      if (hit(addr_i, `OFS_BKPT_HI))     bkpt_hi_o     <= {8'h00, wdata_i[7:0]};
      if (hit(addr_i, `OFS_BKPT_LO))     bkpt_lo_o     <= {wdata_i[15:1], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // reset monitor and self reset
  // ------------------------------------------------------------
  // flags are active low: high means the cause did not occur; a cause
  // arriving with a clear wins over it
  always_ff @(posedge clk_i) begin
    if (~external_unit_reset_n_i) begin
      flags_r <= `RST_FLAGS;
    end else begin
      flags_r <= (wr_clear ? `RST_FLAGS : flags_r)
               & ~{abort_i, self_cnt_r != 4'h0, break_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      self_cnt_r  <= 4'h0;
      cpu_reset_o <= 1'b0;
    end else begin
      if (wr_self) self_cnt_r <= `SELF_RESET_CYCLES;
      else if (self_cnt_r != 4'h0) self_cnt_r <= self_cnt_r - 4'h1;
      cpu_reset_o <= wr_self | (self_cnt_r > 4'h1);
    end
  end

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  always_comb begin
    in_word = `RST_WORD;
    in_word[7:0]           = main_data_i;
    in_word[`BIT_MAIN_STAT] = mainframe_status_in_i;
    in_word[`BIT_ABORT]     = abort_i;
    in_word[`BIT_SUPPLY_OK] = supply_ok_flag_i;
    in_word[`BIT_WAS_BREAK] = flags_r[0];
    in_word[`BIT_WAS_SELF]  = flags_r[1];
    in_word[`BIT_WAS_ABORT] = flags_r[2];
    in_word[15]             = ~break_i;
  end

  always_comb begin
    reg_rdata_nxt = `RST_WORD;
    case (addr_i)
      `OFS_IN_PORT:      reg_rdata_nxt = in_word;
      `OFS_SYNC_STATUS:  reg_rdata_nxt = {9'h000, sync_status_i};
      `OFS_LOW_DRIVE:    reg_rdata_nxt = low_drive_i;
      `OFS_TARGET_LINES: begin
        reg_rdata_nxt = target_lines_i;
        reg_rdata_nxt[`BIT_RESET_STAT] = pod_rst;
      end
      `OFS_CTRL_DRIVE:   reg_rdata_nxt = {1'b0, ctrl_drive_i[14:0]};
      `OFS_DATA_DRIVE:   reg_rdata_nxt = data_drive_i;
      default:           reg_rdata_nxt = `RST_WORD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ram_rd_r    <= 1'b0;
      rd_pend_r   <= 1'b0;
      reg_rdata_r <= `RST_WORD;
    end else begin
      ram_rd_r    <= rd_i & ram_sel;
      rd_pend_r   <= rd_i;
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // mux after the ram register keeps read data one cycle for both sources
  always_comb begin
    rdata_o = ram_rd_r ? ram.rdata : (rd_pend_r ? reg_rdata_r : `RST_WORD);
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign out_port_o            = out_r;
  assign main_data_o           = out_r[7:0];
  assign main_data_oe_o        = oe_r;
  assign status_to_mainframe_o = out_r[`BIT_STATUS_OUT];
  assign busy_counter_carry_o  = ton_carry;
  assign target_on_request_o   = ton_req;
  assign run_target_on_o       = ton_run;
  assign target_on_o           = ton_on;
endmodule // pod_control_status_map
`default_nettype wire

// ### rtl/pod_local_ram.sv
// Purpose: kernel plus overlay read/write ram of the pod
// Assumes: word addressed, 8k words
// Notes:   registered read data
`timescale 1ns/1ps
`default_nettype none
module pod_local_ram #(
  parameter int DEPTH = 8192
) (
  // clock
  input  wire logic clk_i,
  // port
  pod_ram_if.mem    ram
);
  logic [15:0] mem_r [DEPTH];
  always_ff @(posedge clk_i) begin
    if (ram.we) begin
      mem_r[ram.addr] <= ram.wdata;
    end
    ram.rdata <= mem_r[ram.addr];
  end
endmodule // pod_local_ram
`default_nettype wire

// ### rtl/pod_map_consts.svh
// Purpose: offsets, field positions and reset values of the pod control/status map
// Assumes: word-wide pod processor bus, byte address printed as offset
// Notes:   definitions only
`ifndef POD_MAP_CONSTS_SVH
`define POD_MAP_CONSTS_SVH

// ------------------------------------------------------------
// register offsets and ram top
// ------------------------------------------------------------
`define OFS_STANDBY_HI     16'hc000
`define OFS_OUT_PORT       16'hc800
`define OFS_LINE_ENABLE    16'hd000
`define OFS_IN_PORT        16'hd800
`define OFS_SYNC_STATUS    16'he000
`define OFS_UPPER_ADDR     16'he800
`define OFS_LOW_DRIVE      16'hf000
`define OFS_TARGET_LINES   16'hf200
`define OFS_CTRL_DRIVE     16'hf400
`define OFS_DATA_DRIVE     16'hf600
`define OFS_SELF_RESET     16'hf800
`define OFS_MON_CLEAR      16'hf900
`define OFS_TON_REQ        16'hfa00
`define OFS_OVERLAY        16'hfb00
`define OFS_BKPT_HI        16'hfc00
`define OFS_BKPT_LO        16'hfd00
`define RAM_TOP            16'h3ffe

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_ENABLE         8
`define BIT_STATUS_OUT     11
`define BIT_MAIN_STAT      8
`define BIT_ABORT          9
`define BIT_SUPPLY_OK      11
`define BIT_WAS_BREAK      12
`define BIT_WAS_SELF       13
`define BIT_WAS_ABORT      14
`define BIT_RESET_STAT     4

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RST_WORD           16'h0000
`define RST_FLAGS          3'h7
`define SELF_RESET_CYCLES  4'h8
`define TON_CYCLES         4'h4

`endif

// ### rtl/pod_map_pkg.sv
// Purpose: shared types of the pod control/status map
// Assumes: nothing beyond the constants header
// Notes:   types only
package pod_map_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {TON_IDLE, TON_BUSY, TON_RUN} ton_state_t;
endpackage

// ### rtl/pod_ram_if.sv
// Purpose: carrier between the map and its local ram
// Assumes: one word per access
// Notes:   read data registered in the ram
`timescale 1ns/1ps
`default_nettype none
interface pod_ram_if;
  logic        we;
  logic [12:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/pod_target_on.sv
// Purpose: bus switch timing of a target-on cycle
// Assumes: request is a one-cycle pulse
// Notes:   all signals idle high after reset
`timescale 1ns/1ps
`default_nettype none
`include "pod_map_consts.svh"
module pod_target_on (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request
  input  wire logic req_i,
  // timing signals, idle high
  output logic      carry_o,
  output logic      request_o,
  output logic      run_o,
  output logic      on_o
);
  import pod_map_pkg::*;
  ton_state_t st_r;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= TON_IDLE;
      cnt_r <= 4'h0;
    end else begin
      case (st_r)
        TON_IDLE: if (req_i) begin
          st_r <= TON_BUSY;
          cnt_r <= `TON_CYCLES;
        end
        TON_BUSY: begin
          if (cnt_r == 4'h1) st_r <= TON_RUN;
          cnt_r <= cnt_r - 4'h1;
        end
        TON_RUN: st_r <= TON_IDLE;
        default: st_r <= TON_IDLE;
      endcase
    end
  end
  // active low strobes, so idle reads high
  assign request_o = (st_r == TON_IDLE) ? ~req_i : 1'b0;
  assign carry_o   = !(st_r == TON_BUSY && cnt_r == 4'h1);
  assign run_o     = (st_r != TON_RUN);
  assign on_o      = (st_r == TON_IDLE);
endmodule // pod_target_on
`default_nettype wire
